// File: core/bgdc_pkg.sv
package bgdc_pkg;
    // register byte offsets of the controller's own register file
    localparam logic [7:0] BGDC_CTRL_OFS   = 8'h00; // control word
    localparam logic [7:0] BGDC_DUTY_OFS   = 8'h04; // target high count
    localparam logic [7:0] BGDC_PERIOD_OFS = 8'h08; // period in cycles
    localparam logic [7:0] BGDC_STATUS_OFS = 8'h0C; // state readback
    // control field positions
    localparam int BGDC_CTRL_RUN   = 0; // request switching
    localparam int BGDC_CTRL_SKIP  = 1; // skip mode select value
    localparam int BGDC_CTRL_TRI   = 2; // park pwm at tri-state when idle
    localparam int BGDC_CTRL_READY = 3; // device supply released
    // reset values
    localparam logic [31:0] BGDC_CTRL_RST   = 32'h0000_0000;
    localparam logic [15:0] BGDC_DUTY_RST   = 16'h0000;
    localparam logic [15:0] BGDC_PERIOD_RST = 16'h0064;
    // timing: soft-start step interval and disable lead time
    localparam int BGDC_CLK_MHZ      = 100;
    localparam int BGDC_SS_STEP_NS   = 1000;
    localparam int BGDC_SS_STEP_CYC  = (BGDC_SS_STEP_NS * BGDC_CLK_MHZ)
                                       / 1000;
    localparam int BGDC_DIS_LEAD_NS  = 100;
    localparam int BGDC_DIS_LEAD_CYC = (BGDC_DIS_LEAD_NS * BGDC_CLK_MHZ
                                        + 999) / 1000;
    // bus responses
    localparam logic [1:0] BGDC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] BGDC_RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic [1:0] {
        BGDC_IDLE  = 2'b00,
        BGDC_RAMP  = 2'b01,
        BGDC_RUN   = 2'b10,
        BGDC_STOP  = 2'b11
    } bgdc_state_t;
endpackage : bgdc_pkg

// File: core/bgdc_host.sv
// Contract
// - no switching before lockout release
// - start with soft-start duty ramp
// - drop enable before stopping pwm
// - controller watches current, protects load
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module bgdc_host
    import bgdc_pkg::*;
#(
    parameter int PW = 16 // pwm counter width
) (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // axi4-lite write address, data and response
    input  wire logic [7:0]  S_AWADDR,
    input  wire logic        S_AWVALID,
    output logic             S_AWREADY,
    input  wire logic [31:0] S_WDATA,
    input  wire logic [3:0]  S_WSTRB,
    input  wire logic        S_WVALID,
    output logic             S_WREADY,
    output logic [1:0]       S_BRESP,
    output logic             S_BVALID,
    input  wire logic        S_BREADY,
    // axi4-lite read
    input  wire logic [7:0]  S_ARADDR,
    input  wire logic        S_ARVALID,
    output logic             S_ARREADY,
    output logic [31:0]      S_RDATA,
    output logic [1:0]       S_RRESP,
    output logic             S_RVALID,
    input  wire logic        S_RREADY,
    // device pins: pwm is three-level, oe low drives
    output logic             PWM_OUT,
    output logic             PWM_OE_N,
    output logic             DRIVE_ENABLE_INPUT,
    output logic             SKIP_MODE_SELECT,
    // load protection
    input  wire logic        OVER_CURRENT
);
    logic [31:0]       ctrl_q;       // control word
    logic [PW-1:0]     duty_q;       // target high count
    logic [PW-1:0]     period_q;     // period length
    logic [PW-1:0]     cur_duty_q;   // ramped duty
    logic [PW-1:0]     cnt_q;        // period counter
    logic [15:0]       ss_q;         // soft-start step divider
    logic [7:0]        lead_q;       // disable lead counter
    logic              fault_q;      // sticky over-current
    bgdc_state_t       state_q;      // sequencer state
    logic              aw_q, w_q;    // captured write halves
    logic [7:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              ss_tick;      // soft-start step enable
    logic              run_req;      // software wants switching

    assign run_req = ctrl_q[BGDC_CTRL_RUN] & ctrl_q[BGDC_CTRL_READY]
                     & ~fault_q;
    assign ss_tick = (ss_q == 16'(BGDC_SS_STEP_CYC - 1));

    // write channel capture, either order
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            aw_q      <= 1'b0;
            w_q       <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            S_AWREADY <= 1'b0;
            S_WREADY  <= 1'b0;
            S_BVALID  <= 1'b0;
            S_BRESP   <= BGDC_RESP_OKAY;
        end else begin
            S_AWREADY <= ~aw_q & ~S_AWREADY & ~S_BVALID & S_AWVALID;
            S_WREADY  <= ~w_q & ~S_WREADY & ~S_BVALID & S_WVALID;
            if (S_AWVALID && S_AWREADY) begin
                aw_q     <= 1'b1;
                awaddr_q <= S_AWADDR;
            end
            if (S_WVALID && S_WREADY) begin
                w_q     <= 1'b1;
                wdata_q <= S_WDATA;
                wstrb_q <= S_WSTRB;
            end
            // both halves held: answer once
            if (aw_q && w_q && !S_BVALID) begin
                S_BVALID <= 1'b1;
                S_BRESP  <= (awaddr_q == BGDC_STATUS_OFS ||
                             awaddr_q > BGDC_STATUS_OFS)
                            ? BGDC_RESP_SLVERR : BGDC_RESP_OKAY;
            end else if (S_BVALID && S_BREADY) begin
                S_BVALID <= 1'b0;
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
            end
        end
    end

    // register writes, commit with the response
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_q   <= BGDC_CTRL_RST;
            duty_q   <= PW'(BGDC_DUTY_RST);
            period_q <= PW'(BGDC_PERIOD_RST);
        end else if (aw_q && w_q && !S_BVALID && wstrb_q[0]) begin
            case (awaddr_q)
                BGDC_CTRL_OFS:   ctrl_q   <= wdata_q;
                BGDC_DUTY_OFS:   duty_q   <= wdata_q[PW-1:0];
                BGDC_PERIOD_OFS: period_q <= wdata_q[PW-1:0];
                default: ;
            endcase
        end
    end

    // read channel, one cycle to answer
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            S_ARREADY <= 1'b0;
            S_RVALID  <= 1'b0;
            S_RDATA   <= 32'h0000_0000;
            S_RRESP   <= BGDC_RESP_OKAY;
        end else begin
            S_ARREADY <= ~S_ARREADY & ~S_RVALID & S_ARVALID;
            if (S_ARVALID && S_ARREADY) begin
                S_RVALID <= 1'b1;
                S_RRESP  <= BGDC_RESP_OKAY;
                case (S_ARADDR)
                    BGDC_CTRL_OFS:   S_RDATA <= ctrl_q;
                    BGDC_DUTY_OFS:   S_RDATA <= 32'(duty_q);
                    BGDC_PERIOD_OFS: S_RDATA <= 32'(period_q);
                    BGDC_STATUS_OFS: S_RDATA <= {13'h0000, fault_q,
                                                 state_q, cur_duty_q};
                    default: begin
                        S_RDATA <= 32'h0000_0000;
                        S_RRESP <= BGDC_RESP_SLVERR;
                    end
                endcase
            end else if (S_RVALID && S_RREADY) begin
                S_RVALID <= 1'b0;
            end
        end
    end

    // over-current latch; cleared only by dropping run
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            fault_q <= 1'b0;
        end else if (OVER_CURRENT) begin
            fault_q <= 1'b1; // set wins over clear
        end else if (!ctrl_q[BGDC_CTRL_RUN]) begin
            fault_q <= 1'b0;
        end
    end

    // soft-start step divider
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || ss_tick) begin
            ss_q <= 16'h0000;
        end else begin
            ss_q <= ss_q + 16'h0001;
        end
    end

    // sequencer: ramp up, run, disable first then stop
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_q    <= BGDC_IDLE;
            cur_duty_q <= '0;
            lead_q     <= 8'h00;
        end else begin
            case (state_q)
                BGDC_IDLE: begin
                    cur_duty_q <= '0;
                    // only after supply release
                    if (run_req) begin
                        state_q <= BGDC_RAMP;
                    end
                end
                BGDC_RAMP: begin
                    if (!run_req) begin
                        state_q <= BGDC_STOP;
                        lead_q  <= 8'(BGDC_DIS_LEAD_CYC);
                    end else if (cur_duty_q >= duty_q) begin
                        state_q <= BGDC_RUN;
                    end else if (ss_tick) begin
                        cur_duty_q <= cur_duty_q + PW'(1);
                    end
                end
                BGDC_RUN: begin
                    if (!run_req) begin
                        state_q <= BGDC_STOP;
                        lead_q  <= 8'(BGDC_DIS_LEAD_CYC);
                    end else begin
                        // new targets ramp again only upward
                        if (duty_q > cur_duty_q) begin
                            state_q <= BGDC_RAMP;
                        end else begin
                            cur_duty_q <= duty_q;
                        end
                    end
                end
                BGDC_STOP: begin
                    // enable already low; pwm stays alive meanwhile
                    if (lead_q == 8'h00) begin
                        state_q <= BGDC_IDLE;
                    end else begin
                        lead_q <= lead_q - 8'h01;
                    end
                end
                default: state_q <= BGDC_IDLE;
            endcase
        end
    end

    // period counter
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || state_q == BGDC_IDLE || cnt_q >= period_q - PW'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + PW'(1);
        end
    end

    // device pins, all registered
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PWM_OUT            <= 1'b0;
            PWM_OE_N           <= 1'b0;
            DRIVE_ENABLE_INPUT <= 1'b0;
            SKIP_MODE_SELECT   <= 1'b0;
        end else begin
            SKIP_MODE_SELECT <= ctrl_q[BGDC_CTRL_SKIP];
            // enable falls first when stopping
            DRIVE_ENABLE_INPUT <= (state_q == BGDC_RAMP ||
                                   state_q == BGDC_RUN) && run_req;
            if (state_q == BGDC_IDLE) begin
                PWM_OUT  <= 1'b0;
                PWM_OE_N <= ctrl_q[BGDC_CTRL_TRI];
            end else begin
                PWM_OUT  <= (cnt_q < cur_duty_q);
                PWM_OE_N <= 1'b0;
            end
        end
    end
endmodule : bgdc_host

// File: tb/bgdc_host_asserts.sv
`timescale 1ns/1ps
module bgdc_host_asserts (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // bus answers
    input wire logic S_BVALID,
    input wire logic S_BREADY,
    input wire logic S_RVALID,
    input wire logic S_RREADY,
    // device pins and protection
    input wire logic PWM_OUT,
    input wire logic PWM_OE_N,
    input wire logic DRIVE_ENABLE_INPUT,
    input wire logic OVER_CURRENT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] off_q; // cycles since enable dropped, saturating
    // pwm may only rise while enabled or in the short tail after enable falls
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || DRIVE_ENABLE_INPUT)
            off_q <= 8'h00;
        else if (off_q != 8'hFF)
            off_q <= off_q + 8'h01;
    end
    b_hold_a: assert property (S_BVALID && !S_BREADY |=> S_BVALID)
        else $error("write answer dropped early");
    r_hold_a: assert property (S_RVALID && !S_RREADY |=> S_RVALID)
        else $error("read answer dropped early");
    idle_no_pwm_a: assert property (
        $rose(PWM_OUT) |-> DRIVE_ENABLE_INPUT || off_q < 8'h14)
        else $error("pwm toggled while disabled");
    soft_start_a: assert property (
        $rose(DRIVE_ENABLE_INPUT) |-> !PWM_OUT [*8])
        else $error("full duty at start");
    stop_order_a: assert property (
        $fell(DRIVE_ENABLE_INPUT) |-> !PWM_OE_N [*8])
        else $error("pwm stopped before enable");
    fault_stop_a: assert property (
        $rose(OVER_CURRENT) |-> ##[1:4] !DRIVE_ENABLE_INPUT)
        else $error("enable kept on fault");
    cover property ($rose(DRIVE_ENABLE_INPUT));
    cover property ($fell(DRIVE_ENABLE_INPUT));
    cover property ($rose(PWM_OUT));
endmodule : bgdc_host_asserts

// File: tb/bgdc_dev_model.sv
`timescale 1ns/1ps
// behavioural gate decoder standing in for the power stage
module bgdc_dev_model (
    // pins from the controller
    input  wire logic pwm_o,
    input  wire logic pwm_oe_n,
    input  wire logic en,
    input  wire logic skip,
    // gate commands
    output logic      gh,
    output logic      gl
);
    logic sup_ok = 1'b0; // supply above lockout release
    logic seen   = 1'b0; // valid level decoded since enable
    logic tri_q  = 1'b0; // tri-state seen after holdoff
    logic was_hi = 1'b0; // level driven before release
    initial #200 sup_ok = 1'b1;
    // released line sits in the window; short releases are ignored
    always @(pwm_oe_n) begin
        #25 tri_q = pwm_oe_n;
    end
    // note that a valid level was seen, and remember the last one
    always @(pwm_o or pwm_oe_n or en) begin
        seen = en && (seen || !pwm_oe_n);
        if (!pwm_oe_n)
            was_hi = pwm_o;
    end
    // no current sense here, so forward current is assumed
    always_comb begin
        gh = 1'b0;
        gl = 1'b0;
        if (en && sup_ok && seen && !tri_q) begin
            gh = pwm_o;
            gl = !pwm_o;
        end else if (en && sup_ok && seen && !skip && was_hi)
            gl = 1'b1;
    end
endmodule : bgdc_dev_model

// File: tb/buck_gate_drive_control_tb_top.sv
`timescale 1ns/1ps
module buck_gate_drive_control_tb_top;
    import bgdc_pkg::*;
    logic        clk = 1'b0;  // system clock
    logic        rst_n = 1'b0; // reset, active low
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        ovc = 1'b0;   // over-current flag
    logic [3:0]  wstrb = 4'hF; // write lane strobes
    wire logic   awready, wready, bvalid, arready, rvalid;
    wire logic   pwm, pwm_oe_n, en, skip, gh, gl;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    logic [65:0] q[$];         // expected {resp, data, mask}
    logic [65:0] e;
    logic [15:0] d;            // random target duty
    int          n_fail = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          hi = 0;       // pwm high cycles over one period
    bgdc_host i_dut (.SYS_CLK(clk), .RST_N(rst_n),
        .S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready),
        .S_WDATA(wdata), .S_WSTRB(wstrb), .S_WVALID(wvalid),
        .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid),
        .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid),
        .S_ARREADY(arready), .S_RDATA(rdata), .S_RRESP(rresp),
        .S_RVALID(rvalid), .S_RREADY(rready), .PWM_OUT(pwm),
        .PWM_OE_N(pwm_oe_n), .DRIVE_ENABLE_INPUT(en),
        .SKIP_MODE_SELECT(skip), .OVER_CURRENT(ovc));
    bgdc_dev_model i_dev (.pwm_o(pwm), .pwm_oe_n(pwm_oe_n), .en(en),
        .skip(skip), .gh(gh), .gl(gl));
    always #5 clk = ~clk;
    task automatic chk(input logic [33:0] got, input logic [33:0] x);
        total_checks++;
        if (got !== x) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, x);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        bit ta = 1'b1;
        bit tw = 1'b1;
        @(posedge clk);
        q.push_back({r, 64'h0});
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (ta || tw) begin
            @(posedge clk);
            ta = ta && !awready;
            tw = tw && !wready;
            awvalid <= ta;
            wvalid <= tw;
        end
        // late acceptance now and then, so the answer must wait
        repeat ($urandom_range(2, 0)) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] x,
                      input logic [31:0] m);
        @(posedge clk);
        q.push_back({x, m});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        // late acceptance now and then, so the data must stand
        repeat ($urandom_range(2, 0)) @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd
    // compares each bus answer with the oldest note; cuts hangs
    always @(posedge clk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            e = q.pop_front();
            chk(bvalid ? {bresp, 32'h0} : {rresp, rdata & e[31:0]},
                {e[65:64], e[63:32] & e[31:0]});
        end
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h2224));
        d = 16'($urandom_range(8, 3));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(BGDC_CTRL_OFS, {BGDC_RESP_OKAY, BGDC_CTRL_RST}, '1);
        rd(BGDC_PERIOD_OFS, {BGDC_RESP_OKAY, 16'h0, BGDC_PERIOD_RST}, '1);
        rd(BGDC_DUTY_OFS, {BGDC_RESP_OKAY, 16'h0, BGDC_DUTY_RST}, '1);
        rd(8'h10, {BGDC_RESP_SLVERR, 32'h0}, '1);
        wr(BGDC_STATUS_OFS, 32'hFFFF, BGDC_RESP_SLVERR);
        wr(BGDC_CTRL_OFS, 32'h1, BGDC_RESP_OKAY);
        repeat (30) @(posedge clk);
        chk({33'h0, en}, 34'h0);
        wr(BGDC_DUTY_OFS, {16'h0, d}, BGDC_RESP_OKAY);
        wr(BGDC_PERIOD_OFS, 32'h10, BGDC_RESP_OKAY);
        wr(BGDC_CTRL_OFS, 32'hB, BGDC_RESP_OKAY);
        repeat (4) @(posedge clk);
        chk({32'h0, en, skip}, 34'h3);
        repeat (int'(d) * 100 + 50) @(posedge clk);
        rd(BGDC_STATUS_OFS, {BGDC_RESP_OKAY, 14'h0, BGDC_RUN, d},
           32'h3FFFF);
        chk({32'h0, gh, gl}, {32'h0, pwm, !pwm});
        // one full period of 16 cycles holds exactly duty high cycles
        repeat (16) begin
            @(posedge clk);
            hi += int'(pwm);
        end
        chk(34'(hi), 34'(d));
        wr(BGDC_CTRL_OFS, 32'hC, BGDC_RESP_OKAY);
        repeat (30) @(posedge clk);
        chk({32'h0, en, pwm_oe_n}, 34'h1);
        wr(BGDC_CTRL_OFS, 32'h9, BGDC_RESP_OKAY);
        repeat (20) @(posedge clk);
        ovc <= 1'b1;
        @(posedge clk);
        ovc <= 1'b0;
        repeat (5) @(posedge clk);
        chk({33'h0, en}, 34'h0);
        rd(BGDC_STATUS_OFS, {BGDC_RESP_OKAY, 32'h40000}, 32'h40000);
        wr(BGDC_CTRL_OFS, 32'h0, BGDC_RESP_OKAY);
        rd(BGDC_STATUS_OFS, {BGDC_RESP_OKAY, 32'h0}, 32'h40000);
        // a write with no lane enabled must leave the register alone
        wstrb <= 4'h0;
        wr(BGDC_DUTY_OFS, 32'h7, BGDC_RESP_OKAY);
        wstrb <= 4'hF;
        rd(BGDC_DUTY_OFS, {BGDC_RESP_OKAY, 16'h0, d}, '1);
        print_verdict();
    end
endmodule : buck_gate_drive_control_tb_top
bind bgdc_host bgdc_host_asserts i_chk (.SYS_CLK, .RST_N, .S_BVALID,
    .S_BREADY, .S_RVALID, .S_RREADY, .PWM_OUT, .PWM_OE_N,
    .DRIVE_ENABLE_INPUT, .OVER_CURRENT);
